// ===== pkg/dpr_pkg.sv
// Package for the dual-port RAM port controller: timing, widths, commands and carriers.
package dpr_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ADDR_W          = 13;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned FLAG_ADDR_W     = 3;
  // Times in ns as printed; cycle counts derived with the rounding each needs.
  localparam int unsigned T_WC_NS         = 55;
  localparam int unsigned T_WP_NS         = 40;
  localparam int unsigned T_DW_NS         = 30;
  localparam int unsigned T_AW_NS         = 45;
  localparam int unsigned T_WZ_NS         = 25;
  localparam int unsigned T_RC_NS         = 55;
  localparam int unsigned T_AA_NS         = 55;
  localparam int unsigned T_AOE_NS        = 30;
  localparam int unsigned T_SWRD_NS       = 10;
  localparam int unsigned T_SOP_NS        = 15;
  localparam int unsigned T_STANDBY_NS    = 55;
  localparam int unsigned T_WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_WZDW_CYC      = (T_WZ_NS + T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_WC_CYC        = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_AW_CYC        = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_DW_CYC        = (T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_RD_CYC        = ((T_AA_NS > T_AOE_NS ? T_AA_NS : T_AOE_NS) + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned T_RC_CYC        = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_SWRD_CYC      = (T_SWRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_SOP_CYC       = (T_SOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_STANDBY_CYC   = (T_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 4;

  typedef enum logic [1:0] {
    DPR_CMD_RD      = 2'b00,
    DPR_CMD_WR      = 2'b01,
    DPR_CMD_FLAG_RD = 2'b10,
    DPR_CMD_FLAG_WR = 2'b11
  } dpr_cmd_t;

  // Request from user logic.
  typedef struct packed {
    dpr_cmd_t            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [1:0]          be;
  } dpr_req_t;

  // Control pins toward the RAM port, all active low except the address.
  typedef struct packed {
    logic                port_sel_n;
    logic                upper_byte_sel_n;
    logic                lower_byte_sel_n;
    logic                flag_space_sel_n;
    logic                rw_n;
    logic                oe_n;
    logic [ADDR_W-1:0]   addr;
  } dpr_pins_t;
endpackage

// ===== design/dpr_sync.sv
// Three-stage input synchroniser for the data bus read back from the RAM.
`timescale 1ns/1ns
module dpr_sync (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      srst,
  // Asynchronous input and its settled copy
  input  wire logic [dpr_pkg::DATA_W-1:0] din,
  output logic      [dpr_pkg::DATA_W-1:0] dout
);
  typedef struct packed {
    logic [dpr_pkg::DATA_W-1:0] s1;
    logic [dpr_pkg::DATA_W-1:0] s2;
    logic [dpr_pkg::DATA_W-1:0] s3;
    logic [dpr_pkg::DATA_W-1:0] q;
  } dpr_sync_st_t;

  dpr_sync_st_t st;
  dpr_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A bit only changes once the second and third stages agree.
    for (int i = 0; i < dpr_pkg::DATA_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule

// ===== design/dpr_host.sv
// Host controller that drives one port of an asynchronous dual-port RAM with semaphores.
//
// Summary of operation
// - Array access: port low, byte low, flag-space high.
// - Flag access: flag-space low, port or bytes high.
// - Hold select condition steady whole write strobe.
// - Change address only with strobes released.
// - Write strobe longer when output enable low.
// - Cycle 55, strobe 40, data 30 ns.
// - Address and select valid 45 ns before end.
// - Flag read returns flag on all sixteen lines.
// - Wait 10 ns between flag write and read.
// - Flag update strobe held at least 15 ns.
// - Eight flags, address bits 2:0, data bit 0.
`timescale 1ns/1ns
module dpr_host (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // User request side
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire dpr_pkg::dpr_req_t          req,
  // User answer side
  output logic                            rsp_valid,
  output logic [dpr_pkg::DATA_W-1:0]      rsp_data,
  output logic                            flag_granted,
  // RAM port pins
  output dpr_pkg::dpr_pins_t              pins,
  output logic [dpr_pkg::DATA_W-1:0]      data_out,
  output logic                            data_oe,
  input  wire logic [dpr_pkg::DATA_W-1:0] data_in
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_RECOV  = 3'b011,
    ST_READ   = 3'b100,
    ST_DONE   = 3'b101,
    ST_GAP    = 3'b110
  } dpr_state_t;

  typedef struct packed {
    dpr_state_t                  state;
    dpr_pkg::dpr_cmd_t           cmd;
    logic [dpr_pkg::CNT_W-1:0]   cnt;
    logic [dpr_pkg::CNT_W-1:0]   gap;
    dpr_pkg::dpr_pins_t          pins;
    logic [dpr_pkg::DATA_W-1:0]  wdata;
    logic                        data_oe;
    logic                        req_ready;
    logic                        rsp_valid;
    logic [dpr_pkg::DATA_W-1:0]  rsp_data;
    logic                        flag_granted;
  } dpr_st_t;

  dpr_st_t                     st;
  dpr_st_t                     next_st;
  logic [dpr_pkg::DATA_W-1:0]  data_sync;

  localparam logic [dpr_pkg::CNT_W-1:0] C_WP   = dpr_pkg::CNT_W'(dpr_pkg::T_WP_CYC > dpr_pkg::T_SOP_CYC ?
                                                   dpr_pkg::T_WP_CYC : dpr_pkg::T_SOP_CYC);
  localparam logic [dpr_pkg::CNT_W-1:0] C_WZDW = dpr_pkg::CNT_W'(dpr_pkg::T_WZDW_CYC);
  localparam logic [dpr_pkg::CNT_W-1:0] C_RD   = dpr_pkg::CNT_W'(dpr_pkg::T_RD_CYC);
  localparam logic [dpr_pkg::CNT_W-1:0] C_RC   = dpr_pkg::CNT_W'(dpr_pkg::T_RC_CYC);
  localparam logic [dpr_pkg::CNT_W-1:0] C_WC   = dpr_pkg::CNT_W'(dpr_pkg::T_WC_CYC);
  localparam logic [dpr_pkg::CNT_W-1:0] C_SWRD = dpr_pkg::CNT_W'(dpr_pkg::T_SWRD_CYC);

  // Idle pin levels: everything deselected, write line high, outputs disabled.
  function automatic dpr_pkg::dpr_pins_t idle_pins(input logic [dpr_pkg::ADDR_W-1:0] a);
    dpr_pkg::dpr_pins_t p;
    p.port_sel_n       = 1'b1;
    p.upper_byte_sel_n = 1'b1;
    p.lower_byte_sel_n = 1'b1;
    p.flag_space_sel_n = 1'b1;
    p.rw_n             = 1'b1;
    p.oe_n             = 1'b1;
    p.addr             = a;
    return p;
  endfunction

  // Select pattern for the access type, write and output enable still released.
  function automatic dpr_pkg::dpr_pins_t sel_pins(input dpr_pkg::dpr_cmd_t c,
                                                  input logic [dpr_pkg::ADDR_W-1:0] a,
                                                  input logic [1:0] be);
    dpr_pkg::dpr_pins_t p;
    p = idle_pins(a);
    if (c == dpr_pkg::DPR_CMD_FLAG_RD || c == dpr_pkg::DPR_CMD_FLAG_WR) begin
      // Port and both bytes high keep the array out; only the flag index is driven.
      p.flag_space_sel_n = 1'b0;
      p.addr             = {{(dpr_pkg::ADDR_W-dpr_pkg::FLAG_ADDR_W){1'b0}}, a[dpr_pkg::FLAG_ADDR_W-1:0]};
    end else begin
      p.port_sel_n       = 1'b0;
      p.upper_byte_sel_n = ~be[1];
      p.lower_byte_sel_n = ~be[0];
    end
    return p;
  endfunction

  dpr_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .din  (data_in),
    .dout (data_sync)
  );

  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    if (st.gap != '0) begin
      next_st.gap = st.gap - 1'b1;
    end
    case (st.state)
      ST_IDLE: begin
        next_st.req_ready = (st.gap == '0);
        if (st.req_ready && req_valid) begin
          next_st.req_ready = 1'b0;
          next_st.cmd       = req.cmd;
          // Address and selects change only while the write line is high.
          next_st.pins      = sel_pins(req.cmd, req.addr, req.be);
          next_st.wdata     = (req.cmd == dpr_pkg::DPR_CMD_FLAG_WR) ?
                              {{(dpr_pkg::DATA_W-1){1'b1}}, req.wdata[0]} : req.wdata;
          next_st.cnt       = '0;
          next_st.state     = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_st.cnt = '0;
        if (st.cmd == dpr_pkg::DPR_CMD_WR || st.cmd == dpr_pkg::DPR_CMD_FLAG_WR) begin
          // Selects lead the write line, so the RAM outputs were never enabled here.
          next_st.pins.rw_n = 1'b0;
          next_st.data_oe   = 1'b1;
          next_st.state     = ST_STROBE;
        end else begin
          next_st.pins.oe_n = 1'b0;
          next_st.state     = ST_READ;
        end
      end
      ST_STROBE: begin
        // Output enable stays high in writes, so the plain pulse width suffices.
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt + 1'b1 >= C_WP && st.cnt + 1'b1 >= dpr_pkg::CNT_W'(dpr_pkg::T_DW_CYC) &&
            st.cnt + 2'd2 >= dpr_pkg::CNT_W'(dpr_pkg::T_AW_CYC)) begin
          // Selects are held unchanged through the strobe and released with it.
          next_st.pins  = idle_pins(st.pins.addr);
          next_st.cnt   = st.cnt + 2'd2;
          next_st.state = ST_RECOV;
        end
      end
      ST_RECOV: begin
        next_st.data_oe = 1'b0;
        next_st.cnt     = st.cnt + 1'b1;
        if (st.cnt + 1'b1 >= C_WC) begin
          next_st.rsp_valid = 1'b1;
          if (st.cmd == dpr_pkg::DPR_CMD_FLAG_WR) begin
            next_st.gap = C_SWRD;
          end
          next_st.state = ST_GAP;
        end
      end
      ST_READ: begin
        next_st.cnt = st.cnt + 1'b1;
        // Three sync stages plus the output register sit behind the access time.
        if (st.cnt >= C_RD + 3'd4 && st.cnt + 1'b1 >= C_RC) begin
          next_st.rsp_data = (st.cmd == dpr_pkg::DPR_CMD_FLAG_RD) ?
                             {dpr_pkg::DATA_W{data_sync[0]}} : data_sync;
          if (st.cmd == dpr_pkg::DPR_CMD_FLAG_RD) begin
            next_st.flag_granted = ~data_sync[0];
          end
          next_st.rsp_valid = 1'b1;
          next_st.pins      = idle_pins(st.pins.addr);
          next_st.state     = ST_DONE;
        end
      end
      ST_DONE: begin
        next_st.state = ST_GAP;
      end
      ST_GAP: begin
        next_st.req_ready = (st.gap == '0);
        next_st.state     = ST_IDLE;
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st                  <= '0;
      st.state            <= ST_IDLE;
      st.pins.port_sel_n       <= 1'b1;
      st.pins.upper_byte_sel_n <= 1'b1;
      st.pins.lower_byte_sel_n <= 1'b1;
      st.pins.flag_space_sel_n <= 1'b1;
      st.pins.rw_n             <= 1'b1;
      st.pins.oe_n             <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready   = st.req_ready;
  assign rsp_valid   = st.rsp_valid;
  assign rsp_data    = st.rsp_data;
  assign flag_granted = st.flag_granted;
  assign pins        = st.pins;
  assign data_out    = st.wdata;
  assign data_oe     = st.data_oe;
endmodule

// ===== tb/dpr_host_sva.sv
// Concurrent checks on the RAM port pins driven by the port controller.
`timescale 1ns/1ns
module dpr_host_chk (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       srst,
  // User answer side
  input wire logic                       rsp_valid,
  input wire logic                       flag_granted,
  // RAM port
  input wire dpr_pkg::dpr_pins_t         pins,
  input wire logic [dpr_pkg::DATA_W-1:0] data_out,
  input wire logic                       data_oe
);
  logic sel_any;

  assign sel_any = !pins.port_sel_n || !pins.flag_space_sel_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_array_select: assert property (!pins.rw_n && pins.flag_space_sel_n |->
    !pins.port_sel_n && !(pins.upper_byte_sel_n && pins.lower_byte_sel_n)) else $error("array write unselected");
  a_flag_select: assert property (!pins.flag_space_sel_n |-> pins.port_sel_n)
    else $error("flag access with port select");
  a_write_hold: assert property (!pins.rw_n ##1 !pins.rw_n |-> $stable(pins) && $stable(data_out))
    else $error("pins moved during write");
  a_strobe_width: assert property ($fell(pins.rw_n) |-> (!pins.rw_n)[*4]) else $error("write strobe short");
  a_write_spacing: assert property ($fell(pins.rw_n) |=> (!$fell(pins.rw_n))[*5])
    else $error("write cycle short");
  a_data_setup: assert property ($rose(pins.rw_n) |-> $past(data_oe, 3) && $past(sel_any, 5))
    else $error("data or select late before end of write");
  a_output_off: assert property (!pins.rw_n |-> pins.oe_n && data_oe) else $error("output enable during write");
  a_flag_pulse: assert property ($fell(pins.flag_space_sel_n) |-> (!pins.flag_space_sel_n)[*2])
    else $error("flag strobe short");
  cover property (rsp_valid && flag_granted);
  cover property ($fell(pins.oe_n));
  cover property ($fell(pins.flag_space_sel_n));
endmodule

bind dpr_host dpr_host_chk chk (.clk(clk), .srst(srst), .rsp_valid(rsp_valid), .flag_granted(flag_granted),
  .pins(pins), .data_out(data_out), .data_oe(data_oe));

// ===== tb/dpr_ram_model.sv
// Behavioural model of one port of the asynchronous dual-port RAM with eight flags.
`timescale 1ns/1ns
module dpr_ram_model #(
  // Worst-case access time, so the controller's sampling point is tested at its limit.
  parameter int unsigned ACC_NS = 55
) (
  // RAM port pins from the controller
  input  wire dpr_pkg::dpr_pins_t         pins,
  // Bus level and the model's own drive
  input  wire logic [dpr_pkg::DATA_W-1:0] dq,
  output logic      [dpr_pkg::DATA_W-1:0] dev_q
);
  logic [15:0] mem [0:8191];
  logic [7:0]  flag = 8'hFF;
  logic [15:0] last = 16'h0000;
  logic        sel_arr;
  logic        sel_flag;
  logic        rd_en;
  logic [15:0] rd_val;

  initial foreach (mem[i]) mem[i] = 16'h0000;
  assign sel_arr = !pins.port_sel_n && !(pins.upper_byte_sel_n && pins.lower_byte_sel_n) &&
                   pins.flag_space_sel_n;
  assign sel_flag = !pins.flag_space_sel_n &&
                    (pins.port_sel_n || (pins.upper_byte_sel_n && pins.lower_byte_sel_n));
  // A deselected port gives no read data and wakes at once; reads stay off while the write line is low.
  assign rd_en = pins.rw_n && !pins.oe_n && (sel_arr || sel_flag);
  assign rd_val = sel_flag ? {16{flag[pins.addr[2:0]]}} : mem[pins.addr];
  always @* begin
    if (!pins.rw_n && sel_arr) begin
      if (!pins.lower_byte_sel_n) mem[pins.addr][7:0] = dq[7:0];
      if (!pins.upper_byte_sel_n) mem[pins.addr][15:8] = dq[15:8];
    end
    // With the far port idle every claim wins.
    if (!pins.rw_n && sel_flag) flag[pins.addr[2:0]] = dq[0];
  end
  always @(rd_en or rd_val) if (rd_en) last = rd_val;
  // A released bus shows the inverse of the last word so stale data never passes for fresh.
  assign #(ACC_NS) dev_q = rd_en ? rd_val : ~last;
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the RAM port controller against the behavioural RAM model.
`timescale 1ns/1ns
module testbench;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              req_valid = 1'b0;
  logic              req_ready;
  dpr_pkg::dpr_req_t req = '0;
  logic              rsp_valid;
  logic [15:0]       rsp_data;
  logic              flag_granted;
  dpr_pkg::dpr_pins_t pins;
  logic [15:0]       data_out;
  logic              data_oe;
  logic [15:0]       dq;
  logic [15:0]       dev_q;
  logic [15:0]       ref_mem [logic [12:0]];
  int                n_mismatch = 0;
  int                comparisons = 0;
  int                cycles = 0;

  always #5 clk = ~clk;
  assign dq = data_oe ? data_out : dev_q;
  dpr_host dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .flag_granted(flag_granted), .pins(pins),
    .data_out(data_out), .data_oe(data_oe), .data_in(dq));
  dpr_ram_model ram (.pins(pins), .dq(dq), .dev_q(dev_q));

  function automatic logic [15:0] merge(logic [15:0] old, logic [15:0] nw, logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      results();
    end
  end
  // The request is held until an edge that sees ready high, then dropped at that edge.
  task automatic issue(dpr_pkg::dpr_cmd_t cmd, logic [12:0] a, logic [15:0] wd, logic [1:0] be);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{cmd: cmd, addr: a, wdata: wd, be: be};
    do @(negedge clk); while (req_ready !== 1'b1 && ++n < 50);
    @(posedge clk);
    req_valid <= 1'b0;
    do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 80);
    if (n >= 80) check("response", 16'h0000, 16'hFFFF);
    @(negedge clk);
  endtask

  initial begin
    logic [12:0] a;
    logic [15:0] w;
    logic [1:0]  be;
    void'($urandom(43675));
    for (int j = 0; j < 16; j++) ref_mem[13'(j)] = 16'h0000;
    ref_mem[13'h1FFF] = 16'h0000;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // Array ends with lower, upper, then both lanes first, then random writes each followed by a random read.
    for (int i = 0; i < 50; i++) begin
      a = (i < 3) ? {13{i[0]}} : 13'($urandom_range(0, 15));
      w = 16'($urandom);
      be = (i < 3) ? 2'(i + 1) : 2'($urandom_range(1, 3));
      ref_mem[a] = merge(ref_mem[a], w, be);
      issue(dpr_pkg::DPR_CMD_WR, a, w, be);
      if (i >= 3) a = 13'($urandom_range(0, 15));
      issue(dpr_pkg::DPR_CMD_RD, a, 16'h0000, 2'b11);
      check("array read", rsp_data, ref_mem[a]);
    end
    // Upper address bits are noise for the flags; each flag is claimed and freed on its own.
    for (int f = 0; f < 8; f++) begin
      a = {10'($urandom), 3'(f)};
      issue(dpr_pkg::DPR_CMD_FLAG_RD, a, 16'h0000, 2'b11);
      check("free flag", rsp_data, 16'hFFFF);
      issue(dpr_pkg::DPR_CMD_FLAG_WR, a, 16'hFFFE, 2'b11);
      issue(dpr_pkg::DPR_CMD_FLAG_RD, a, 16'h0000, 2'b11);
      check("owned flag", rsp_data, 16'h0000);
      check("grant", {15'h0000, flag_granted}, 16'h0001);
      issue(dpr_pkg::DPR_CMD_FLAG_RD, a ^ 13'h0001, 16'h0000, 2'b11);
      check("other flag", rsp_data, 16'hFFFF);
      issue(dpr_pkg::DPR_CMD_FLAG_WR, a ^ 13'h1FF8, 16'h0001, 2'b11);
      issue(dpr_pkg::DPR_CMD_FLAG_RD, a, 16'h0000, 2'b11);
      check("released flag", rsp_data, 16'hFFFF);
      check("grant freed", {15'h0000, flag_granted}, 16'h0000);
    end
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    // Looked at mid-cycle, once the reset values have settled.
    @(negedge clk);
    check("selects in reset", {10'h000, pins.port_sel_n, pins.upper_byte_sel_n, pins.lower_byte_sel_n,
      pins.flag_space_sel_n, pins.rw_n, pins.oe_n}, 16'h003F);
    check("address in reset", {3'h0, pins.addr}, 16'h0000);
    check("drive in reset", {14'h0000, req_ready, data_oe}, 16'h0000);
    @(posedge clk);
    srst <= 1'b0;
    issue(dpr_pkg::DPR_CMD_RD, 13'h1FFF, 16'h0000, 2'b11);
    check("read after reset", rsp_data, ref_mem[13'h1FFF]);
    results();
  end
endmodule
